// File: include/vfm_map.svh
// valve feedback monitor: register offsets, field positions, reset values, timing counts
// assumes a 125 MHz core clock and a 10 ms evaluation tick
//
// Summary of operation
// - single, double or directional valve configurations
// - switch-on timeout 50 ms-10 s, zero disables
// - switch-off timeout 50 ms-10 s, zero disables
// - reset pulse 100/350 ms minimum, 30 s maximum
// - output rises on control rise with read-back high
// - output low on control low or any error
// - output two follows control one or two
// - control rise with read-back low sets error
// - read-back not falling within switch-on timeout errors
// - read-back not rising within switch-off timeout errors
// - continuous monitoring: read-back rising while active errors
// - directional: both controls high sets directional error
// - summary flag is OR of both errors
// - errors clear on safe state, plus pulse if manual
`ifndef VFM_MAP_SVH
`define VFM_MAP_SVH

// register byte offsets
`define VFM_REG_CTRL 8'h00
`define VFM_REG_T_ON 8'h04
`define VFM_REG_T_OFF 8'h08
`define VFM_REG_STATE 8'h0C
`define VFM_REG_IRQ_STS 8'h10
`define VFM_REG_IRQ_CLR 8'h14
`define VFM_REG_IRQ_EN 8'h18

// control register fields
`define VFM_CTRL_TYPE_LSB 0
`define VFM_CTRL_MANUAL_BIT 2
`define VFM_CTRL_CONT_BIT 3
`define VFM_CTRL_LONG_BIT 4

// interrupt bit positions
`define VFM_IRQ_RB_ERR 0
`define VFM_IRQ_DIR_ERR 1
`define VFM_IRQ_CLEARED 2
`define VFM_IRQ_PULSE_BAD 3

// reset values
`define VFM_CTRL_RST 5'h00
`define VFM_TMR_RST 10'h000
`define VFM_IRQ_EN_RST 4'h0

// timing
`define VFM_CLK_PERIOD_NS 8
`define VFM_TICK_MS 10
`define VFM_TICK_CYCLES ((`VFM_TICK_MS * 1000000) / `VFM_CLK_PERIOD_NS)
`define VFM_PULSE_SHORT_MS 100
`define VFM_PULSE_LONG_MS 350
`define VFM_PULSE_MAX_MS 30000
`define VFM_PULSE_SHORT_TICKS (`VFM_PULSE_SHORT_MS / `VFM_TICK_MS)
`define VFM_PULSE_LONG_TICKS (`VFM_PULSE_LONG_MS / `VFM_TICK_MS)
`define VFM_PULSE_MAX_TICKS (`VFM_PULSE_MAX_MS / `VFM_TICK_MS)

`endif

// File: include/vfm_pkg.sv
// valve feedback monitor: shared types
// assumes vfm_map.svh for all numeric constants
package vfm_pkg;

  typedef enum logic [1:0] {
    VFM_SINGLE = 2'h0,
    VFM_DOUBLE = 2'h1,
    VFM_DIRECT = 2'h2
  } vfm_type_t;

  typedef enum logic [2:0] {
    VFM_IDLE = 3'b001,
    VFM_ON_WAIT = 3'b010,
    VFM_OFF_WAIT = 3'b100
  } vfm_phase_t;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
  } vfm_sync_t;

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic [1:0] vtype;
    logic manual;
    logic cont;
    logic long_pulse;
    logic [9:0] t_on;
    logic [9:0] t_off;
    vfm_phase_t [1:0] phase;
    logic [1:0][9:0] tmr;
    logic [1:0] ctrl_prev;
    logic [1:0] rb_prev;
    logic rst_prev;
    logic [11:0] pulse_w;
    logic valve1;
    logic valve2;
    logic rb_err;
    logic dir_err;
    logic err_flag;
    logic [3:0] irq_sts;
    logic [3:0] irq_en;
    logic irq;
    logic [31:0] rdata;
  } vfm_state_t;

endpackage

// File: tb/tb.sv
// self-checking bench for the valve feedback monitor
// assumes vfm_map.svh on the include path and a 4-cycle tick
`timescale 1ns/1ps
`default_nettype none
`include "vfm_map.svh"

module tb;
  localparam int unsigned TK = 4;
  localparam int PW[5] = '{5, 3100, 14, 20, 40};
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic ctrl1 = 1'b0, ctrl2 = 1'b0, btn = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic valve1, valve2, rb_err, dir_err, err_flag, irq, rb1, rb2;
  logic [15:0] dly1 = 16'h0002;
  logic stk1 = 1'b0, stkv1 = 1'b0;
  logic [9:0] v;
  logic [4:0] pin_q = 5'h00;
  logic [7:0] rst_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};
  int err_total = 0;
  int n_checks = 0;
  int seed = 19;
  string nm_q [$];
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];

  always #4 i_core_clk = ~i_core_clk;

  vfm_monitor #(.P_TICK_CYCLES(TK)) u_dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_ctrl1(ctrl1), .i_ctrl2(ctrl2), .i_readback1(rb1), .i_readback2(rb2), .i_reset_btn(btn),
    .o_valve1(valve1), .o_valve2(valve2), .o_rb_err(rb_err), .o_dir_err(dir_err),
    .o_err_flag(err_flag), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));
  vfm_valve_model u_v1 (.i_clk(i_core_clk), .i_drive(valve1), .i_delay(dly1), .i_stuck(stk1),
    .i_stuck_val(stkv1), .o_readback(rb1));
  vfm_valve_model u_v2 (.i_clk(i_core_clk), .i_drive(valve2), .i_delay(16'h0002),
    .i_stuck(1'b0), .i_stuck_val(1'b0), .o_readback(rb2));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask

  // note the expectation, then issue the read
  task automatic rd_exp(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    nm_q.push_back(n);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
  endtask

  task automatic chk_st(input logic [4:0] e);
    rd_exp("state", `VFM_REG_STATE, {27'h000_0000, e}, 32'h0000_001F);
  endtask

  task automatic make_err();
    stk1 <= 1'b1;
    stkv1 <= 1'b0;
    cyc(3);
    ctrl1 <= 1'b1;
    cyc(3);
    stk1 <= 1'b0;
    ctrl1 <= 1'b0;
    cyc(6);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge i_core_clk)
  begin
    rd_q <= rd;
    pin_q <= {err_flag, dir_err, rb_err, valve2, valve1};
    if (rd_q && exp_q.size() != 0)
    begin
      // pins one cycle back line up with the state word read
      if (nm_q[0] == "state")
        check("pins", {27'h000_0000, pin_q}, exp_q[0] & 32'h0000_001F);
      check(nm_q.pop_front(), rdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (100000) @(posedge i_core_clk);
    err_total++;
    $display("MISMATCH watchdog expected end seen hang");
    summarize();
  end

  initial
  begin
    cyc(12);
    i_reset <= 1'b0;
    cyc(4);
    foreach (rst_addr[i])
      rd_exp("reset", rst_addr[i], 32'h0000_0000, 32'hFFFF_FFFF);
    chk_st(5'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = 10'(5 + ($unsigned($random(seed)) % 996));
      wr_reg(`VFM_REG_T_ON, {22'h00_0000, v});
      rd_exp("t_on", `VFM_REG_T_ON, {22'h00_0000, v}, 32'h0000_03FF);
      wr_reg(`VFM_REG_T_OFF, {22'h00_0000, 10'h3ED - v});
      rd_exp("t_off", `VFM_REG_T_OFF, {22'h00_0000, 10'h3ED - v}, 32'h0000_03FF);
    end
    wr_reg(`VFM_REG_T_OFF, 32'h0000_0000);
    wr_reg(`VFM_REG_T_ON, 32'h0000_0005);
    wr_reg(`VFM_REG_IRQ_EN, 32'h0000_000F);
    // single valve, prompt contact
    ctrl1 <= 1'b1;
    cyc(3);
    chk_st(5'h01);
    cyc(30);
    chk_st(5'h01);
    ctrl1 <= 1'b0;
    cyc(3);
    chk_st(5'h00);
    // rise with contact low
    stk1 <= 1'b1;
    cyc(4);
    ctrl1 <= 1'b1;
    cyc(3);
    chk_st(5'h14);
    check("irq", {31'h0000_0000, irq}, 32'h0000_0001);
    rd_exp("irq_sts", `VFM_REG_IRQ_STS, 32'h0000_0001, 32'h0000_0001);
    stk1 <= 1'b0;
    cyc(6);
    chk_st(5'h14);
    ctrl1 <= 1'b0;
    cyc(5);
    chk_st(5'h00);
    rd_exp("irq_sts", `VFM_REG_IRQ_STS, 32'h0000_0005, 32'h0000_0005);
    wr_reg(`VFM_REG_IRQ_CLR, 32'h0000_000F);
    rd_exp("irq_sts", `VFM_REG_IRQ_STS, 32'h0000_0000, 32'h0000_000F);
    check("irq", {31'h0000_0000, irq}, 32'h0000_0000);
    // slow contact misses switch-on window
    dly1 <= 16'h0064;
    ctrl1 <= 1'b1;
    cyc(12);
    chk_st(5'h01);
    cyc(20);
    chk_st(5'h14);
    ctrl1 <= 1'b0;
    cyc(5);
    chk_st(5'h00);
    // switch-on check off, switch-off window missed
    wr_reg(`VFM_REG_T_ON, 32'h0000_0000);
    wr_reg(`VFM_REG_T_OFF, 32'h0000_0005);
    dly1 <= 16'h0028;
    ctrl1 <= 1'b1;
    cyc(50);
    chk_st(5'h01);
    ctrl1 <= 1'b0;
    cyc(30);
    chk_st(5'h14);
    cyc(20);
    chk_st(5'h00);
    // continuous monitoring, switch-on check kept nonzero
    dly1 <= 16'h0002;
    wr_reg(`VFM_REG_T_OFF, 32'h0000_0000);
    wr_reg(`VFM_REG_T_ON, 32'h0000_0005);
    wr_reg(`VFM_REG_CTRL, 32'h0000_0008);
    ctrl1 <= 1'b1;
    cyc(10);
    chk_st(5'h01);
    stk1 <= 1'b1;
    stkv1 <= 1'b1;
    cyc(4);
    chk_st(5'h14);
    stk1 <= 1'b0;
    ctrl1 <= 1'b0;
    cyc(5);
    chk_st(5'h00);
    // double valve
    wr_reg(`VFM_REG_CTRL, 32'h0000_0001);
    ctrl2 <= 1'b1;
    cyc(3);
    chk_st(5'h02);
    ctrl1 <= 1'b1;
    cyc(3);
    chk_st(5'h03);
    ctrl1 <= 1'b0;
    ctrl2 <= 1'b0;
    cyc(6);
    // directional valve
    wr_reg(`VFM_REG_CTRL, 32'h0000_0002);
    ctrl1 <= 1'b1;
    cyc(4);
    chk_st(5'h03);
    ctrl2 <= 1'b1;
    cyc(3);
    chk_st(5'h1C);
    ctrl1 <= 1'b0;
    ctrl2 <= 1'b0;
    cyc(8);
    chk_st(5'h00);
    wr_reg(`VFM_REG_IRQ_CLR, 32'h0000_000F);
    // manual reset pulses: short, overlong, valid; then the long minimum
    wr_reg(`VFM_REG_CTRL, 32'h0000_0004);
    make_err();
    chk_st(5'h14);
    for (int i = 0; i < 5; i++)
    begin
      if (i == 3)
      begin
        wr_reg(`VFM_REG_CTRL, 32'h0000_0014);
        make_err();
      end
      btn <= 1'b1;
      cyc(PW[i] * TK);
      btn <= 1'b0;
      cyc(6);
      chk_st((i == 2 || i == 4) ? 5'h00 : 5'h14);
      rd_exp("irq_sts", `VFM_REG_IRQ_STS, (i == 2 || i == 4) ? 32'h0000_0004 : 32'h0000_0008,
        32'h0000_000C);
      wr_reg(`VFM_REG_IRQ_CLR, 32'h0000_000F);
    end
    for (int k = 0; k < 10 && exp_q.size() != 0; k++)
      cyc(1);
    if (exp_q.size() != 0)
      check("queue", 32'h0000_0001, 32'h0000_0000);
    summarize();
  end
endmodule // tb

`default_nettype wire

// File: tb/vfm_valve_model.sv
// valve actuator with one read-back contact, behavioural
// assumes the contact reads high while the valve is at rest
`timescale 1ns/1ps
`default_nettype none

module vfm_valve_model (
  // clock
  input wire logic i_clk,
  // coil drive and behaviour knobs
  input wire logic i_drive,
  input wire logic [15:0] i_delay,
  input wire logic i_stuck,
  input wire logic i_stuck_val,
  // contact back to the monitor
  output logic o_readback
);
  logic pos_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;

  // valve travels i_delay+1 cycles after the coil changes
  always @(posedge i_clk)
  begin
    if (i_drive == pos_q)
      cnt_q <= 16'h0000;
    else if (cnt_q >= i_delay)
    begin
      pos_q <= i_drive;
      cnt_q <= 16'h0000;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  // contact is the inverse of the valve position unless welded
  assign o_readback = i_stuck ? i_stuck_val : ~pos_q;
endmodule // vfm_valve_model

`default_nettype wire

// File: verilog/vfm_monitor.sv
// valve feedback monitor: valve drive, read-back checks, error latching, register port
// assumes control inputs are on i_core_clk; read-backs and reset button are pins
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "vfm_map.svh"

module vfm_monitor #(
  parameter int unsigned P_TICK_CYCLES = `VFM_TICK_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // control from logic
  input wire logic i_ctrl1,
  input wire logic i_ctrl2,
  // pins from valves and reset button
  input wire logic i_readback1,
  input wire logic i_readback2,
  input wire logic i_reset_btn,
  // valve drive and errors
  output logic o_valve1,
  output logic o_valve2,
  output logic o_rb_err,
  output logic o_dir_err,
  output logic o_err_flag,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // interrupt
  output logic o_irq
);
  import vfm_pkg::*;

  vfm_state_t st_q;
  vfm_state_t st_d;
  logic [2:0] pin_s;
  logic [1:0] c;
  logic [1:0] r;
  logic [1:0] en;
  logic [1:0] rise;
  logic [1:0] err_ev;
  logic clr_ok;
  logic pulse_ok;
  logic pulse_bad;
  logic rst_fall;
  logic [11:0] pulse_min;

  function automatic logic timed_out(input logic [9:0] n, input logic [9:0] lim);
    timed_out = (lim != 10'h000) && (n >= lim);
  endfunction

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  vfm_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_async({i_reset_btn, i_readback2, i_readback1}),
    .o_sync(pin_s)
  );

  always_comb
  begin
    st_d = st_q;
    // 10 ms evaluation tick
    st_d.tick = 1'b0;
    if (st_q.tick_cnt == 32'(P_TICK_CYCLES - 1))
    begin
      st_d.tick_cnt = 32'h0000_0000;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;
    end

    // channel association per valve type
    c[0] = i_ctrl1;
    c[1] = i_ctrl2;
    r = pin_s[1:0];
    en[0] = 1'b1;
    en[1] = (st_q.vtype == VFM_DOUBLE) || (st_q.vtype == VFM_DIRECT);
    err_ev = 2'b00;
    rise = 2'b00;

    for (int i = 0; i < 2; i++)
    begin
      rise[i] = c[i] && !st_q.ctrl_prev[i];
      case (st_q.phase[i])
        VFM_IDLE:
        begin
          st_d.tmr[i] = 10'h000;
        end
        VFM_ON_WAIT:
        begin
          if (!r[i])
          begin
            st_d.phase[i] = VFM_IDLE;
          end
          else if (st_q.tick)
          begin
            st_d.tmr[i] = st_q.tmr[i] + 10'h001;
            if (timed_out(st_d.tmr[i], st_q.t_on))
            begin
              err_ev[i] = 1'b1;
              st_d.phase[i] = VFM_IDLE;
            end
          end
        end
        VFM_OFF_WAIT:
        begin
          if (r[i])
          begin
            st_d.phase[i] = VFM_IDLE;
          end
          else if (st_q.tick)
          begin
            st_d.tmr[i] = st_q.tmr[i] + 10'h001;
            if (timed_out(st_d.tmr[i], st_q.t_off))
            begin
              err_ev[i] = 1'b1;
              st_d.phase[i] = VFM_IDLE;
            end
          end
        end
        default:
        begin
          st_d.phase[i] = VFM_IDLE;
        end
      endcase
      if (rise[i])
      begin
        st_d.tmr[i] = 10'h000;
        if (!r[i])
        begin
          err_ev[i] = 1'b1;
        end
        // zero switch-on time leaves the channel idle
        st_d.phase[i] = (r[i] && st_q.t_on != 10'h000) ? VFM_ON_WAIT : VFM_IDLE;
      end
      else if (!c[i] && st_q.ctrl_prev[i])
      begin
        st_d.tmr[i] = 10'h000;
        st_d.phase[i] = (!r[i] && st_q.t_off != 10'h000) ? VFM_OFF_WAIT : VFM_IDLE;
      end
      else if (st_q.cont && c[i] && r[i] && !st_q.rb_prev[i])
      begin
        err_ev[i] = 1'b1;
      end
      if (!en[i])
      begin
        err_ev[i] = 1'b0;
        st_d.phase[i] = VFM_IDLE;
      end
    end
    st_d.ctrl_prev = c;
    st_d.rb_prev = r;

    // reset pulse width qualification
    pulse_min = st_q.long_pulse ? 12'(`VFM_PULSE_LONG_TICKS) : 12'(`VFM_PULSE_SHORT_TICKS);
    rst_fall = st_q.rst_prev && !pin_s[2];
    pulse_ok = rst_fall && (st_q.pulse_w >= pulse_min) && (st_q.pulse_w <= 12'(`VFM_PULSE_MAX_TICKS));
    pulse_bad = rst_fall && !pulse_ok;
    st_d.rst_prev = pin_s[2];
    if (!pin_s[2])
    begin
      st_d.pulse_w = 12'h000;
    end
    else if (st_q.tick && st_q.pulse_w <= 12'(`VFM_PULSE_MAX_TICKS))
    begin
      st_d.pulse_w = st_q.pulse_w + 12'h001;
    end

    // error latching, set wins over clear
    clr_ok = !(c[0] || (en[1] && c[1])) && r[0] && (!en[1] || r[1]) && (!st_q.manual || pulse_ok);
    st_d.rb_err = (|err_ev) || (st_q.rb_err && !clr_ok);
    st_d.dir_err = (st_q.vtype == VFM_DIRECT && c[0] && c[1]) || (st_q.dir_err && !clr_ok);
    st_d.err_flag = st_d.rb_err || st_d.dir_err;

    // valve drive
    if (st_d.err_flag || !c[0])
    begin
      st_d.valve1 = 1'b0;
    end
    else if (rise[0] && r[0])
    begin
      st_d.valve1 = 1'b1;
    end
    if (st_q.vtype == VFM_DIRECT)
    begin
      if (st_d.err_flag || !c[0])
      begin
        st_d.valve2 = 1'b0;
      end
      else if (rise[0] && r[1])
      begin
        st_d.valve2 = 1'b1;
      end
    end
    else if (st_q.vtype == VFM_DOUBLE)
    begin
      if (st_d.err_flag || !c[1])
      begin
        st_d.valve2 = 1'b0;
      end
      else if (rise[1] && r[1])
      begin
        st_d.valve2 = 1'b1;
      end
    end
    else
    begin
      st_d.valve2 = 1'b0;
    end

    // register writes
    if (i_reg_wr)
    begin
      if (reg_hit(i_reg_addr, `VFM_REG_CTRL))
      begin
        st_d.vtype = i_reg_wdata[`VFM_CTRL_TYPE_LSB +: 2];
        st_d.manual = i_reg_wdata[`VFM_CTRL_MANUAL_BIT];
        st_d.cont = i_reg_wdata[`VFM_CTRL_CONT_BIT];
        st_d.long_pulse = i_reg_wdata[`VFM_CTRL_LONG_BIT];
      end
      if (reg_hit(i_reg_addr, `VFM_REG_T_ON))
      begin
        st_d.t_on = i_reg_wdata[9:0];
      end
      if (reg_hit(i_reg_addr, `VFM_REG_T_OFF))
      begin
        st_d.t_off = i_reg_wdata[9:0];
      end
      if (reg_hit(i_reg_addr, `VFM_REG_IRQ_EN))
      begin
        st_d.irq_en = i_reg_wdata[3:0];
      end
      if (reg_hit(i_reg_addr, `VFM_REG_IRQ_CLR))
      begin
        st_d.irq_sts = st_q.irq_sts & ~i_reg_wdata[3:0];
      end
    end
    // sticky events, set wins over clear
    st_d.irq_sts[`VFM_IRQ_RB_ERR] = st_d.irq_sts[`VFM_IRQ_RB_ERR] | (st_d.rb_err & !st_q.rb_err);
    st_d.irq_sts[`VFM_IRQ_DIR_ERR] = st_d.irq_sts[`VFM_IRQ_DIR_ERR] | (st_d.dir_err & !st_q.dir_err);
    st_d.irq_sts[`VFM_IRQ_CLEARED] = st_d.irq_sts[`VFM_IRQ_CLEARED] | (st_q.err_flag & !st_d.err_flag);
    st_d.irq_sts[`VFM_IRQ_PULSE_BAD] = st_d.irq_sts[`VFM_IRQ_PULSE_BAD] | pulse_bad;
    st_d.irq = |(st_d.irq_sts & st_d.irq_en);

    // register reads, data valid one cycle after the strobe only
    st_d.rdata = 32'h0000_0000;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `VFM_REG_CTRL: st_d.rdata = {27'h000_0000, st_q.long_pulse, st_q.cont, st_q.manual, st_q.vtype};
        `VFM_REG_T_ON: st_d.rdata = {22'h00_0000, st_q.t_on};
        `VFM_REG_T_OFF: st_d.rdata = {22'h00_0000, st_q.t_off};
        `VFM_REG_STATE: st_d.rdata = {24'h00_0000, pin_s, st_q.err_flag, st_q.dir_err, st_q.rb_err,
                                      st_q.valve2, st_q.valve1};
        `VFM_REG_IRQ_STS: st_d.rdata = {28'h000_0000, st_q.irq_sts};
        `VFM_REG_IRQ_EN: st_d.rdata = {28'h000_0000, st_q.irq_en};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      st_q <= '0;
      st_q.phase[0] <= VFM_IDLE;
      st_q.phase[1] <= VFM_IDLE;
      st_q.t_on <= `VFM_TMR_RST;
      st_q.t_off <= `VFM_TMR_RST;
      st_q.irq_en <= `VFM_IRQ_EN_RST;
      {st_q.long_pulse, st_q.cont, st_q.manual, st_q.vtype} <= `VFM_CTRL_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_valve1 = st_q.valve1;
  assign o_valve2 = st_q.valve2;
  assign o_rb_err = st_q.rb_err;
  assign o_dir_err = st_q.dir_err;
  assign o_err_flag = st_q.err_flag;
  assign o_reg_rdata = st_q.rdata;
  assign o_irq = st_q.irq;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_ctrl1_rise;
    !i_ctrl1 ##1 i_ctrl1;
  endsequence

  a_valve_rise_cause: assert property ($rose(o_valve1) |->
      $past(i_ctrl1) && !$past(st_q.ctrl_prev[0]) && $past(pin_s[0]))
    else $error("valve one rose without a control rise");
  a_valve_off_ctrl: assert property (!i_ctrl1 |=> !o_valve1)
    else $error("valve one high while control one low");
  a_valve_off_err: assert property (o_err_flag |-> !o_valve1 && !o_valve2)
    else $error("valve driven while an error is latched");
  a_rise_rb_low: assert property (s_ctrl1_rise ##0 !pin_s[0] |=> o_rb_err && o_err_flag)
    else $error("control rise with read-back low did not latch error");
  a_on_timeout: assert property (st_q.phase[0] == VFM_ON_WAIT && pin_s[0] && st_q.tick
      && timed_out(st_q.tmr[0] + 10'h001, st_q.t_on) |=> o_rb_err)
    else $error("switch-on timeout did not raise read-back error");
  a_dir_conflict: assert property (st_q.vtype == VFM_DIRECT && i_ctrl1 && i_ctrl2 |=> o_dir_err && !o_valve2)
    else $error("both directional controls high without error");
  a_flag_is_or: assert property (o_err_flag == (o_rb_err || o_dir_err))
    else $error("summary flag differs from error OR");
  a_clear_cause: assert property ($fell(o_err_flag) |-> $past(clr_ok))
    else $error("errors cleared without the clear condition");
  a_pulse_bounds: assert property (pulse_ok |-> st_q.pulse_w >= 12'(`VFM_PULSE_SHORT_TICKS)
      && st_q.pulse_w <= 12'(`VFM_PULSE_MAX_TICKS))
    else $error("reset pulse accepted outside width bounds");
  a_tick_single: assert property (st_q.tick |=> !st_q.tick || P_TICK_CYCLES == 1)
    else $error("evaluation tick longer than one cycle");

endmodule // vfm_monitor

`default_nettype wire

// File: verilog/vfm_sync.sv
// valve feedback monitor: two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to i_core_clk
`timescale 1ns/1ps
`default_nettype none

module vfm_sync
  import vfm_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // pins in, synchronised out
  input wire logic [2:0] i_async,
  output logic [2:0] o_sync
);

  vfm_sync_t st_q;
  vfm_sync_t st_d;

  always_comb
  begin
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.sync;

endmodule // vfm_sync

`default_nettype wire
